/* File: verilog/cbu_branch_unit.v */
`timescale 1ns/1ps
`include "cbu_regs.vh"

// What this block does
// - Target is delay-slot address plus sign-extended offset shifted left two.
// - A taken branch redirects the PC only after the delay slot issued.
// - Equal-likely branch is taken when both operand registers match in full.
// - Likely branches nullify the delay slot when their condition is false.
// - Nonnegative branch, register-immediate selector 00001, taken when bit 63 clear.
// - Nonnegative likely branch, selector 00011, uses clear sign bit, nullifies.
// - Link forms 10001 and 10011 always write PC plus 8 to register 31.
// - Link branch naming register 31 as first operand raises no exception.
// - Positive branches taken when sign bit clear and operand nonzero.
// - Nonpositive branches taken when sign bit set or operand zero.
// - Negative branch, selector 00000, taken when bit 63 is set.
// - Positive and nonpositive forms test only the first operand against zero.
module cbu_branch_unit (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Issue stage
   input wire issue_valid,
   input wire [31:0] issue_instr,
   input wire [63:0] issue_pc,
   input wire pipe_flush,
   // Operand values read from the register file
   input wire [63:0] first_operand_value,
   input wire [63:0] second_operand_value,
   // Decode answer in the issue cycle
   output wire branch_hit,
   output wire slot_nullify,
   // PC redirect
   output reg pc_redirect,
   output reg [63:0] pc_redirect_target,
   // Link register write
   output reg link_wr_en,
   output reg [4:0] link_wr_idx,
   output reg [63:0] link_wr_data,
   // Status
   output wire slot_pending,
   output reg last_taken,
   output reg branch_exception
);

   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_SLOT = 2'b10;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg taken_r;
   reg likely_r;
   reg [63:0] target_r;

   wire dec_hit;
   wire dec_likely;
   wire dec_link;
   wire [`CBU_CK_W-1:0] dec_kind;
   wire [63:0] slot_pc;
   wire [63:0] tgt_pc;
   wire [63:0] link_pc;
   wire sign_set;
   wire is_zero;
   wire [`CBU_CK_W-1:0] kind_true;
   wire cond_true;
   wire new_branch;
   wire slot_issue;

   cbu_decode u_decode (
      .instr(issue_instr),
      .hit(dec_hit),
      .likely(dec_likely),
      .link(dec_link),
      .cond_kind(dec_kind)
   );

   cbu_target u_target (
      .branch_pc(issue_pc),
      .offset(issue_instr[`CBU_OFF_HI:`CBU_OFF_LO]),
      .slot_pc(slot_pc),
      .target(tgt_pc),
      .link_pc(link_pc)
   );

   // Condition evaluation on the first operand; the equal test also reads the second
   assign sign_set = first_operand_value[`CBU_SIGN_BIT];
   assign is_zero = (first_operand_value == `CBU_ZERO64);
   assign kind_true[`CBU_CK_EQ] = (first_operand_value == second_operand_value);
   assign kind_true[`CBU_CK_NONNEG] = ~sign_set;
   assign kind_true[`CBU_CK_POS] = ~sign_set & ~is_zero;
   assign kind_true[`CBU_CK_NONPOS] = sign_set | is_zero;
   assign kind_true[`CBU_CK_NEG] = sign_set;
   assign cond_true = |(kind_true & dec_kind);

   // Instruction issued while a branch waits is its delay slot
   assign slot_issue = issue_valid & state_r[1] & ~pipe_flush;
   // A branch sitting in a delay slot is treated as the slot only
   assign new_branch = issue_valid & dec_hit & state_r[0] & ~pipe_flush;

   assign branch_hit = dec_hit & issue_valid & state_r[0];
   // Non-likely or taken branches leave the slot alone
   assign slot_nullify = slot_issue & likely_r & ~taken_r;
   assign slot_pending = state_r[1];

   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (new_branch) begin
               state_nxt = ST_SLOT;
            end
         end
         ST_SLOT: begin
            // Wait for the delay slot to issue, however long the stall
            if (slot_issue | pipe_flush) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Branch outcome held until the slot issues
   always @(posedge sys_clk) begin
      if (rst) begin
         taken_r <= 1'b0;
         likely_r <= 1'b0;
         target_r <= `CBU_ZERO64;
         last_taken <= 1'b0;
      end else if (new_branch) begin
         taken_r <= cond_true;
         likely_r <= dec_likely;
         target_r <= tgt_pc;
         last_taken <= cond_true;
      end
   end

   // Redirect one cycle after the delay slot issued
   always @(posedge sys_clk) begin
      if (rst) begin
         pc_redirect <= 1'b0;
         pc_redirect_target <= `CBU_ZERO64;
      end else begin
         pc_redirect <= slot_issue & taken_r;
         if (slot_issue & taken_r) begin
            pc_redirect_target <= target_r;
         end
      end
   end

   // Link write happens taken or not; rs equal to 31 is not checked
   always @(posedge sys_clk) begin
      if (rst) begin
         link_wr_en <= 1'b0;
         link_wr_idx <= `CBU_LINK_REG;
         link_wr_data <= `CBU_ZERO64;
      end else begin
         link_wr_en <= new_branch & dec_link;
         link_wr_idx <= `CBU_LINK_REG;
         if (new_branch & dec_link) begin
            link_wr_data <= link_pc;
         end
      end
   end

   // This group never traps, so the flag stays low
   always @(posedge sys_clk) begin
      if (rst) begin
         branch_exception <= 1'b0;
      end else begin
         branch_exception <= 1'b0;
      end
   end

endmodule // cbu_branch_unit

/* File: verilog/cbu_regs.vh */
`ifndef CBU_REGS_VH
`define CBU_REGS_VH

// Instruction field positions
`define CBU_OP_HI 31
`define CBU_OP_LO 26
`define CBU_RS_HI 25
`define CBU_RS_LO 21
`define CBU_RT_HI 20
`define CBU_RT_LO 16
`define CBU_OFF_HI 15
`define CBU_OFF_LO 0

// Major opcodes
`define CBU_OP_REGISTER_IMMEDIATE_GROUP 6'h01
`define CBU_OP_EQ_LIKELY 6'h14
`define CBU_OP_POS 6'h07
`define CBU_OP_POS_LIKELY 6'h17
`define CBU_OP_NONPOS 6'h06
`define CBU_OP_NONPOS_LIKELY 6'h16

// Selectors under the register-immediate group
`define CBU_RT_NEG 5'h00
`define CBU_RT_NONNEG 5'h01
`define CBU_RT_NONNEG_LIKELY 5'h03
`define CBU_RT_NONNEG_LINK 5'h11
`define CBU_RT_NONNEG_LINK_LIKELY 5'h13

// Datapath constants
`define CBU_SIGN_BIT 63
`define CBU_OFF_SHIFT 2
`define CBU_SLOT_STEP 64'h0000000000000004
`define CBU_LINK_STEP 64'h0000000000000008
`define CBU_LINK_REG 5'h1f
`define CBU_ZERO64 64'h0000000000000000

// Condition kinds, one bit each
`define CBU_CK_W 5
`define CBU_CK_EQ 0
`define CBU_CK_NONNEG 1
`define CBU_CK_POS 2
`define CBU_CK_NONPOS 3
`define CBU_CK_NEG 4

`endif

/* File: verilog/cbu_decode.v */
`timescale 1ns/1ps
`include "cbu_regs.vh"

module cbu_decode (
   // Instruction word
   input wire [31:0] instr,
   // Decoded class
   output reg hit,
   output reg likely,
   output reg link,
   output reg [`CBU_CK_W-1:0] cond_kind
);

   wire [5:0] major_op;
   wire [4:0] sel_field;

   assign major_op = instr[`CBU_OP_HI:`CBU_OP_LO];
   assign sel_field = instr[`CBU_RT_HI:`CBU_RT_LO];

   always @* begin
      hit = 1'b1;
      likely = 1'b0;
      link = 1'b0;
      cond_kind = {`CBU_CK_W{1'b0}};
      case (major_op)
         `CBU_OP_EQ_LIKELY: begin
            cond_kind[`CBU_CK_EQ] = 1'b1;
            likely = 1'b1;
         end
         // Selector field of these four is not examined
         `CBU_OP_POS: cond_kind[`CBU_CK_POS] = 1'b1;
         `CBU_OP_POS_LIKELY: begin
            cond_kind[`CBU_CK_POS] = 1'b1;
            likely = 1'b1;
         end
         `CBU_OP_NONPOS: cond_kind[`CBU_CK_NONPOS] = 1'b1;
         `CBU_OP_NONPOS_LIKELY: begin
            cond_kind[`CBU_CK_NONPOS] = 1'b1;
            likely = 1'b1;
         end
         `CBU_OP_REGISTER_IMMEDIATE_GROUP: begin
            case (sel_field)
               `CBU_RT_NEG: cond_kind[`CBU_CK_NEG] = 1'b1;
               `CBU_RT_NONNEG: cond_kind[`CBU_CK_NONNEG] = 1'b1;
               `CBU_RT_NONNEG_LIKELY: begin
                  cond_kind[`CBU_CK_NONNEG] = 1'b1;
                  likely = 1'b1;
               end
               `CBU_RT_NONNEG_LINK: begin
                  cond_kind[`CBU_CK_NONNEG] = 1'b1;
                  link = 1'b1;
               end
               `CBU_RT_NONNEG_LINK_LIKELY: begin
                  cond_kind[`CBU_CK_NONNEG] = 1'b1;
                  link = 1'b1;
                  likely = 1'b1;
               end
               default: hit = 1'b0;
            endcase
         end
         default: hit = 1'b0;
      endcase
   end

endmodule // cbu_decode

/* File: verilog/cbu_target.v */
`timescale 1ns/1ps
`include "cbu_regs.vh"

module cbu_target (
   // Branch address and offset
   input wire [63:0] branch_pc,
   input wire [15:0] offset,
   // Results
   output wire [63:0] slot_pc,
   output wire [63:0] target,
   output wire [63:0] link_pc
);

   wire [63:0] off_ext;

   // Wraps silently: no address exception is raised here
   assign off_ext = {{(64-16-`CBU_OFF_SHIFT){offset[15]}}, offset,
                     {`CBU_OFF_SHIFT{1'b0}}};
   assign slot_pc = branch_pc + `CBU_SLOT_STEP;
   assign target = slot_pc + off_ext;
   assign link_pc = branch_pc + `CBU_LINK_STEP;

endmodule // cbu_target

/* File: verif/cbu_checker.sv */
`timescale 1ns/1ps
module cbu_checker (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Watched ports
   input wire issue_valid,
   input wire [31:0] issue_instr,
   input wire [63:0] issue_pc,
   input wire pipe_flush,
   input wire [63:0] first_operand_value,
   input wire [63:0] second_operand_value,
   input wire branch_hit,
   input wire slot_nullify,
   input wire slot_pending,
   input wire pc_redirect,
   input wire link_wr_en,
   input wire [4:0] link_wr_idx,
   input wire [63:0] link_wr_data,
   input wire last_taken,
   input wire branch_exception
);
   wire [5:0] op = issue_instr[31:26];
   wire [63:0] fv = first_operand_value;
   // A flush in the issue cycle drops the branch, so it is not accepted
   wire hit_kept = branch_hit && !pipe_flush;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_no_exception:
      assert property (!branch_exception) else $error("exception raised");
   a_link_write:
      assert property (hit_kept && op == 6'h01 && issue_instr[20] |=> link_wr_en &&
         link_wr_idx == 5'h1f && link_wr_data == $past(issue_pc) + 64'h8)
      else $error("bad link write");
   a_register_immediate_group_cond:
      assert property (hit_kept && op == 6'h01 |=>
         last_taken == ($past(fv[63]) ^ $past(issue_instr[16]))) else $error("bad sign test");
   a_equal_cond:
      assert property (hit_kept && op == 6'h14 |=>
         last_taken == ($past(fv) == $past(second_operand_value))) else $error("bad compare");
   a_pos_cond:
      assert property (hit_kept && op[2:0] == 3'b111 |=>
         last_taken == ($past(fv) != 64'h0 && !$past(fv[63]))) else $error("bad positive");
   a_nonpos_cond:
      assert property (hit_kept && op[2:0] == 3'b110 |=>
         last_taken == ($past(fv[63]) || $past(fv) == 64'h0)) else $error("bad nonpositive");
   a_hit_pends:
      assert property (hit_kept |-> issue_valid && !slot_pending ##1 slot_pending)
      else $error("slot not pending");
   a_redirect_slot:
      assert property (pc_redirect |-> $past(slot_pending && issue_valid && !pipe_flush))
      else $error("early redirect");
   a_nullify_cause:
      assert property (slot_nullify |-> slot_pending && issue_valid && !last_taken)
      else $error("bad nullify");
   cover property (pc_redirect);
   cover property (slot_nullify);
   cover property (link_wr_en);
endmodule // cbu_checker

bind cbu_branch_unit cbu_checker u_chk (.sys_clk(sys_clk), .rst(rst),
   .issue_valid(issue_valid), .issue_instr(issue_instr), .issue_pc(issue_pc),
   .pipe_flush(pipe_flush), .first_operand_value(first_operand_value),
   .second_operand_value(second_operand_value), .branch_hit(branch_hit),
   .slot_nullify(slot_nullify), .slot_pending(slot_pending), .pc_redirect(pc_redirect),
   .link_wr_en(link_wr_en), .link_wr_idx(link_wr_idx), .link_wr_data(link_wr_data),
   .last_taken(last_taken), .branch_exception(branch_exception));

/* File: verif/cbu_branch_unit_tb_top.sv */
`timescale 1ns/1ps
module cbu_branch_unit_tb_top;
   localparam logic [63:0] neg = 64'h8000000000000000;
   logic sys_clk, rst, issue_valid, pipe_flush;
   logic [31:0] issue_instr;
   logic [63:0] issue_pc, first_operand_value, second_operand_value, pc;
   wire branch_hit, slot_nullify, pc_redirect, link_wr_en, slot_pending;
   wire last_taken, branch_exception;
   wire [63:0] pc_redirect_target, link_wr_data;
   wire [4:0] link_wr_idx;
   int n_mismatch = 0;
   int check_count = 0;
   cbu_branch_unit dut (.sys_clk(sys_clk), .rst(rst), .issue_valid(issue_valid),
      .issue_instr(issue_instr), .issue_pc(issue_pc), .pipe_flush(pipe_flush),
      .first_operand_value(first_operand_value), .second_operand_value(second_operand_value),
      .branch_hit(branch_hit), .slot_nullify(slot_nullify), .pc_redirect(pc_redirect),
      .pc_redirect_target(pc_redirect_target), .link_wr_en(link_wr_en),
      .link_wr_idx(link_wr_idx), .link_wr_data(link_wr_data), .slot_pending(slot_pending),
      .last_taken(last_taken), .branch_exception(branch_exception));
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task report_and_stop;
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Branch, then its slot, then the redirect cycle
   task automatic br(input logic [31:0] ins, input logic [63:0] a, b, input logic tk, lk);
      logic lnk;
      lnk = ins[31:26] == 6'h01 && ins[20];
      @(posedge sys_clk) #1;
      issue_valid = 1'b1;
      issue_instr = ins;
      issue_pc = pc;
      first_operand_value = a;
      second_operand_value = b;
      #1 check("hit", 1'b1, branch_hit);
      @(posedge sys_clk) #1;
      // Slot sees scrambled operands; outcome must already be latched
      issue_instr = 32'h0;
      issue_pc = pc + 64'h4;
      first_operand_value = ~a;
      second_operand_value = ~b;
      check("pending", 1'b1, slot_pending);
      check("link_en", lnk, link_wr_en);
      if (lnk) check("link_data", pc + 64'h8, link_wr_data);
      if (lnk) check("link_idx", 64'h1f, link_wr_idx);
      #1 check("nullify", lk & !tk, slot_nullify);
      @(posedge sys_clk) #1;
      issue_valid = 1'b0;
      check("redirect", tk, pc_redirect);
      check("taken", tk, last_taken);
      if (tk) check("target", pc + 64'h4 + {{46{ins[15]}}, ins[15:0], 2'b00},
         pc_redirect_target);
      check("exception", 1'b0, branch_exception);
      pc = pc + 64'h100;
   endtask
   task flush_drop;
      @(posedge sys_clk) #1;
      issue_valid = 1'b1;
      issue_instr = {6'h01, 5'd4, 5'h01, 16'h0040};
      first_operand_value = 64'h5;
      @(posedge sys_clk) #1;
      issue_valid = 1'b0;
      pipe_flush = 1'b1;
      @(posedge sys_clk) #1;
      pipe_flush = 1'b0;
      issue_valid = 1'b1;
      issue_instr = {6'h04, 5'd1, 5'd1, 16'h0004};
      check("flush_pending", 1'b0, slot_pending);
      #1 check("foreign_hit", 1'b0, branch_hit);
      @(posedge sys_clk) #1;
      issue_valid = 1'b0;
      check("flush_redirect", 1'b0, pc_redirect);
   endtask
   // Stalled slot that is itself a group branch: only the slot counts
   task slot_gap;
      @(posedge sys_clk) #1;
      issue_valid = 1'b1;
      issue_instr = {6'h07, 5'd5, 5'd0, 16'h0002};
      issue_pc = pc;
      first_operand_value = 64'h3;
      @(posedge sys_clk) #1;
      issue_valid = 1'b0;
      @(posedge sys_clk) #1;
      issue_valid = 1'b1;
      issue_instr = {6'h16, 5'd5, 5'd0, 16'h0004};
      issue_pc = pc + 64'h4;
      check("gap_pending", 1'b1, slot_pending);
      check("gap_early", 1'b0, pc_redirect);
      #1 check("slot_hit", 1'b0, branch_hit);
      check("gap_nullify", 1'b0, slot_nullify);
      @(posedge sys_clk) #1;
      issue_valid = 1'b0;
      check("gap_redirect", 1'b1, pc_redirect);
      check("gap_target", pc + 64'h4 + 64'h8, pc_redirect_target);
      check("gap_taken", 1'b1, last_taken);
      pc = pc + 64'h100;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      #200000;
      n_mismatch++;
      report_and_stop;
   end
   initial begin
      {rst, issue_valid, pipe_flush, issue_instr, issue_pc} = '0;
      {first_operand_value, second_operand_value} = '0;
      rst = 1'b1;
      pc = 64'h1000;
      repeat (16) @(posedge sys_clk);
      #1 rst = 1'b0;
      br({6'h14, 5'd1, 5'd2, 16'hfffe}, 64'h1234, 64'h1234, 1'b1, 1'b1);
      br({6'h14, 5'd1, 5'd2, 16'h0008}, neg, neg ^ 64'h1, 1'b0, 1'b1);
      br({6'h01, 5'd3, 5'h01, 16'h8000}, 64'h0, 64'h9, 1'b1, 1'b0);
      br({6'h01, 5'd3, 5'h01, 16'h0010}, neg, 64'h0, 1'b0, 1'b0);
      br({6'h01, 5'd7, 5'h03, 16'h7fff}, ~neg, 64'h0, 1'b1, 1'b1);
      br({6'h01, 5'd7, 5'h03, 16'h0001}, neg, 64'h0, 1'b0, 1'b1);
      br({6'h01, 5'd2, 5'h11, 16'h0020}, neg, 64'h0, 1'b0, 1'b0);
      br({6'h01, 5'd31, 5'h13, 16'hff00}, 64'h0, 64'h0, 1'b1, 1'b1);
      br({6'h01, 5'd31, 5'h13, 16'h0004}, neg, 64'h0, 1'b0, 1'b1);
      br({6'h07, 5'd5, 5'd0, 16'h0004}, 64'h0, 64'h5, 1'b0, 1'b0);
      br({6'h17, 5'd5, 5'd0, 16'h0004}, 64'h1, 64'h0, 1'b1, 1'b1);
      br({6'h06, 5'd5, 5'd0, 16'h0004}, 64'h0, 64'h7, 1'b1, 1'b0);
      br({6'h16, 5'd5, 5'd0, 16'h0004}, 64'h1, 64'h0, 1'b0, 1'b1);
      br({6'h16, 5'd5, 5'd0, 16'h0004}, neg, 64'h0, 1'b1, 1'b1);
      br({6'h01, 5'd9, 5'h00, 16'h0004}, neg, 64'h0, 1'b1, 1'b0);
      br({6'h01, 5'd9, 5'h00, 16'h0004}, ~neg, 64'h0, 1'b0, 1'b0);
      flush_drop;
      slot_gap;
      report_and_stop;
   end
endmodule // cbu_branch_unit_tb_top
